// ### qpc_defines.svh
// register offsets, field positions, reset values and timing counts of the pulse counter
`ifndef QPC_DEFINES_SVH
`define QPC_DEFINES_SVH
`define QPC_A_CTRL     4'h0
`define QPC_A_TERM     4'h1
`define QPC_A_PRESET   4'h2
`define QPC_A_CMPLO    4'h3
`define QPC_A_CMPHI    4'h4
`define QPC_A_PPR      4'h5
`define QPC_A_REFR     4'h6
`define QPC_A_STAT     4'h7
`define QPC_A_COUNT    4'h8
`define QPC_A_RPM      4'h9
`define QPC_C_RUN      0
`define QPC_C_RING     1
`define QPC_C_MODE_LO  2
`define QPC_C_MODE_HI  3
`define QPC_C_EXTPRE   4
`define QPC_C_INTPRE   5
`define QPC_C_LATCH    6
`define QPC_C_CMP_LO   7
`define QPC_C_CMP_HI   8
`define QPC_C_TASK     9
`define QPC_C_PAIR     10
`define QPC_C_W        11
`define QPC_RST_CTRL   11'h000
`define QPC_RST_WORD   32'h00000000
`define QPC_RST_PPR    16'h0001
`define QPC_RST_REFR   16'h0001
`define QPC_E_NONE     8'h00
`define QPC_E_MODE     8'h10
`define QPC_E_RING     8'h11
`define QPC_E_ZONE     8'h12
`define QPC_E_BOTH     8'h13
`define QPC_CNT_MAX    32'sh7fffffff
`define QPC_CNT_MIN    32'sh80000000
`define QPC_RING_MIN   32'sh00000002
`define QPC_RPM_K      64'sh000000000000ea60
`define QPC_MS_NS      1000000
`define QPC_CLK_NS     10
`endif

// ### qpc_pkg.sv
// types shared by the pulse counter
package qpc_pkg;
  typedef enum logic [1:0] {
    QPC_ONE_PHASE = 2'b00,
    QPC_PULSE_DIR = 2'b01,
    QPC_CW_CCW    = 2'b10,
    QPC_QUAD_X4   = 2'b11
  } qpc_mode_t;
  typedef enum logic [1:0] {
    QPC_CMP_OFF   = 2'b00,
    QPC_CMP_POINT = 2'b01,
    QPC_CMP_ZONE  = 2'b10,
    QPC_CMP_RSVD  = 2'b11
  } qpc_cmp_t;
endpackage : qpc_pkg

// ### qpc_counter.sv
// 32-bit signed quadrature pulse counter channel with register port
// What this block does
// [R1] counting is accepted only while the run command is set
// [R2] clearing run stops counting, drops comparison output, keeps the count
// [R3] count is a 32-bit two's-complement value over the full signed range
// [R4] compare flag sets when count exceeds terminal value, clears when below
// [R5] linear overflow sets carry, underflow sets borrow, both halt; run-off clears
// [R6] preset clears carry and borrow and lets a halted linear counter resume
// [R7] ring up-count reaching terminal value sets carry and reloads zero
// [R8] ring down-count from zero sets borrow and loads terminal value minus one
// [R9] bad ring setting or preset raises code 11, runs linear until restart
// [R10] mode error 10 when a 2-phase channel's partner channel is also used
// [R11] 1-phase mode counts up on each rising edge of the count input
// [R12] pulse-direction mode counts on A rising, up if B low, down if high
// [R13] cw/ccw mode counts on A rising with B low and B rising with A low
// [R14] cw/ccw mode treats A pulses as up and B pulses as down
// [R15] x4 mode increments on the four forward phase edges
// [R16] x4 mode decrements on the four reverse phase edges
// [R17] rising edge of the chosen preset source loads the preset value
// [R18] with latch set the count is kept when run restarts, else cleared
// [R19] point mode drives the comparison output while count equals low compare
// [R20] zone mode output inside low..high; high below low gives code 12, disabled
// [R21] comparison task pulses the interrupt each time count becomes equal to low
// [R22] each refresh period speed is diff times 60000 over pulses times period
// [R23] phase and preset pins are synchronised and edge detected, one action per edge
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "qpc_defines.svh"
module qpc_counter #(
  parameter int MS_CYCLES = `QPC_MS_NS / `QPC_CLK_NS
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        phase_a,
  input  wire logic        phase_b,
  input  wire logic        preset_pin,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             cmp_out,
  output logic             cmp_irq,
  output logic             compare_flag_bit,
  output logic             overflow_flag_bit,
  output logic             underflow_flag_bit
);
  import qpc_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [2:0] s1_q, s1_d, s2_q, s2_d, pv_q, pv_d;
  always_comb
  begin
    s1_d = {preset_pin, phase_b, phase_a};
    s2_d = s1_q;
    pv_d = s2_q;
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      pv_q <= 3'h0;
    end
    else if (ce)
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      pv_q <= pv_d;
    end
  end
  logic a, b, ar, af, br, bf, pin_pre_rise;
  assign a            = s2_q[0];
  assign b            = s2_q[1];
  assign ar           = a & ~pv_q[0];  // see [R23]
  assign af           = ~a & pv_q[0];
  assign br           = b & ~pv_q[1];
  assign bf           = ~b & pv_q[1];
  assign pin_pre_rise = s2_q[2] & ~pv_q[2];

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic [10:0] ctrl_q, ctrl_d;
  logic signed [31:0] term_q, term_d, pre_q, pre_d, lo_q, lo_d, hi_q, hi_d;
  logic [15:0] ppr_q, ppr_d, refr_q, refr_d;
  always_comb
  begin
    ctrl_d = ctrl_q;
    term_d = term_q;
    pre_d  = pre_q;
    lo_d   = lo_q;
    hi_d   = hi_q;
    ppr_d  = ppr_q;
    refr_d = refr_q;
    if (wr)
    begin
      case (addr)
        `QPC_A_CTRL:   ctrl_d = wdata[10:0];
        `QPC_A_TERM:   term_d = wdata;
        `QPC_A_PRESET: pre_d  = wdata;
        `QPC_A_CMPLO:  lo_d   = wdata;
        `QPC_A_CMPHI:  hi_d   = wdata;
        `QPC_A_PPR:    ppr_d  = wdata[15:0];
        `QPC_A_REFR:   refr_d = wdata[15:0];
        default:       ctrl_d = ctrl_q;
      endcase
    end
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl_q <= `QPC_RST_CTRL;
      term_q <= `QPC_RST_WORD;
      pre_q  <= `QPC_RST_WORD;
      lo_q   <= `QPC_RST_WORD;
      hi_q   <= `QPC_RST_WORD;
      ppr_q  <= `QPC_RST_PPR;
      refr_q <= `QPC_RST_REFR;
    end
    else if (ce)
    begin
      ctrl_q <= ctrl_d;
      term_q <= term_d;
      pre_q  <= pre_d;
      lo_q   <= lo_d;
      hi_q   <= hi_d;
      ppr_q  <= ppr_d;
      refr_q <= refr_d;
    end
  end
  logic      run, ring, latch, task_en, pair_used;
  qpc_mode_t mode;
  qpc_cmp_t  cmode;
  assign run       = ctrl_q[`QPC_C_RUN];
  assign ring      = ctrl_q[`QPC_C_RING];
  assign latch     = ctrl_q[`QPC_C_LATCH];
  assign task_en   = ctrl_q[`QPC_C_TASK];
  assign pair_used = ctrl_q[`QPC_C_PAIR];
  assign mode      = qpc_mode_t'(ctrl_q[`QPC_C_MODE_HI:`QPC_C_MODE_LO]);
  assign cmode     = qpc_cmp_t'(ctrl_q[`QPC_C_CMP_HI:`QPC_C_CMP_LO]);

  // ----------------------------------------------------------------
  // count decode
  // ----------------------------------------------------------------
  logic up, dn;
  always_comb
  begin
    case (mode)
      QPC_ONE_PHASE:
      begin
        up = ar;  // see [R11]
        dn = 1'b0;
      end
      QPC_PULSE_DIR:
      begin
        up = ar & ~b;  // see [R12]
        dn = ar & b;
      end
      QPC_CW_CCW:
      begin
        up = ar & ~b;  // see [R13] see [R14]
        dn = br & ~a;
      end
      default:
      begin
        up = (ar & ~b) | (af & b) | (br & a) | (bf & ~a);  // see [R15]
        dn = (ar & b) | (af & ~b) | (br & ~a) | (bf & a);  // see [R16]
      end
    endcase
  end
  logic mode_err, tv_ok, pre_ok, zone_err;
  assign mode_err = (mode != QPC_ONE_PHASE) & pair_used;  // see [R10]
  assign tv_ok    = term_q >= `QPC_RING_MIN;
  assign pre_ok   = pre_q >= `QPC_RING_MIN;
  assign zone_err = (cmode == QPC_CMP_ZONE) & (hi_q < lo_q);  // see [R20]

  // ----------------------------------------------------------------
  // counter core
  // ----------------------------------------------------------------
  logic signed [31:0] cnt_q, cnt_d;
  logic carry_q, carry_d, borrow_q, borrow_d, halt_q, halt_d;
  logic rerr_q, rerr_d, run_q, ipre_q, cmpf_q, cmpf_d;
  logic pre_rise, run_rise, ring_act, step_ok;
  assign pre_rise = ctrl_q[`QPC_C_EXTPRE] ? pin_pre_rise
                                          : (ctrl_q[`QPC_C_INTPRE] & ~ipre_q);
  assign run_rise = run & ~run_q;
  assign ring_act = ring & ~rerr_q & tv_ok;
  assign step_ok  = run & ~halt_q & ~mode_err & (up ^ dn);  // see [R1]
  always_comb
  begin
    cnt_d    = cnt_q;
    carry_d  = carry_q;
    borrow_d = borrow_q;
    halt_d   = halt_q;
    rerr_d   = rerr_q;
    if (!run)
    begin
      carry_d  = 1'b0;  // see [R5]
      borrow_d = 1'b0;
      halt_d   = 1'b0;
    end
    if (run_rise)
    begin
      rerr_d = 1'b0;  // see [R9]
      if (!latch)
        cnt_d = `QPC_RST_WORD;  // see [R18]
    end
    else if (pre_rise)
    begin
      cnt_d    = pre_q;  // see [R17]
      carry_d  = 1'b0;  // see [R6]
      borrow_d = 1'b0;
      halt_d   = 1'b0;
      if (ring && !pre_ok)
        rerr_d = 1'b1;  // see [R9]
    end
    else if (step_ok && up)
    begin
      if (ring_act && (cnt_q + 32'sh1 >= term_q))
      begin
        cnt_d   = `QPC_RST_WORD;  // see [R7]
        carry_d = 1'b1;
      end
      else if (!ring_act && cnt_q == `QPC_CNT_MAX)
      begin
        carry_d = 1'b1;  // see [R5]
        halt_d  = 1'b1;
      end
      else
        cnt_d = cnt_q + 32'sh1;  // see [R3]
    end
    else if (step_ok && dn)
    begin
      if (ring_act && cnt_q <= `QPC_RST_WORD)
      begin
        cnt_d    = term_q - 32'sh1;  // see [R8]
        borrow_d = 1'b1;
      end
      else if (!ring_act && cnt_q == `QPC_CNT_MIN)
      begin
        borrow_d = 1'b1;  // see [R5]
        halt_d   = 1'b1;
      end
      else
        cnt_d = cnt_q - 32'sh1;
    end
    if (run && ring && !tv_ok)
      rerr_d = 1'b1;  // see [R9]
    cmpf_d = cmpf_q;
    if (cnt_q > term_q)
      cmpf_d = 1'b1;  // see [R4]
    else if (cnt_q < term_q)
      cmpf_d = 1'b0;
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_q    <= `QPC_RST_WORD;
      carry_q  <= 1'b0;
      borrow_q <= 1'b0;
      halt_q   <= 1'b0;
      rerr_q   <= 1'b0;
      run_q    <= 1'b0;
      ipre_q   <= 1'b0;
      cmpf_q   <= 1'b0;
    end
    else if (ce)
    begin
      cnt_q    <= cnt_d;
      carry_q  <= carry_d;
      borrow_q <= borrow_d;
      halt_q   <= halt_d;
      rerr_q   <= rerr_d;
      run_q    <= run;
      ipre_q   <= ctrl_q[`QPC_C_INTPRE];
      cmpf_q   <= cmpf_d;
    end
  end

  // ----------------------------------------------------------------
  // comparison output and task interrupt
  // ----------------------------------------------------------------
  logic out_q, out_d, irq_q, irq_d, eq_q, eq;
  logic [7:0] err;
  assign eq = cnt_q == lo_q;
  always_comb
  begin
    case (cmode)
      QPC_CMP_POINT: out_d = run & eq;  // see [R19] see [R2]
      QPC_CMP_ZONE:  out_d = run & ~zone_err & (cnt_q >= lo_q) & (cnt_q <= hi_q);  // see [R20]
      default:       out_d = 1'b0;
    endcase
    irq_d = run & task_en & eq & ~eq_q;  // see [R21]
    if (mode_err)
      err = `QPC_E_MODE;
    else if (rerr_q && zone_err)
      err = `QPC_E_BOTH;
    else if (rerr_q)
      err = `QPC_E_RING;
    else if (zone_err)
      err = `QPC_E_ZONE;
    else
      err = `QPC_E_NONE;
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      out_q <= 1'b0;
      irq_q <= 1'b0;
      eq_q  <= 1'b0;
    end
    else if (ce)
    begin
      out_q <= out_d;
      irq_q <= irq_d;
      eq_q  <= eq;
    end
  end

  // ----------------------------------------------------------------
  // speed measurement
  // ----------------------------------------------------------------
  logic [31:0] ms_q, ms_d;
  logic [15:0] per_q, per_d;
  logic signed [31:0] last_q, last_d, rpm_q, rpm_d, diff;
  logic signed [63:0] num, den;
  assign diff = cnt_q - last_q;
  assign num  = 64'(diff) * `QPC_RPM_K;
  assign den  = $signed({32'h0, 32'(ppr_q) * 32'(refr_q)});
  always_comb
  begin
    ms_d   = ms_q + 32'h1;
    per_d  = per_q;
    last_d = last_q;
    rpm_d  = rpm_q;
    if (!run)
    begin
      ms_d   = 32'h0;
      per_d  = 16'h0;
      last_d = cnt_q;
    end
    else if (ms_q >= 32'(MS_CYCLES - 1))
    begin
      ms_d  = 32'h0;
      per_d = per_q + 16'h1;
      if (per_q + 16'h1 >= refr_q)
      begin
        per_d  = 16'h0;
        last_d = cnt_q;
        if (den != 64'sh0)
          rpm_d = 32'(num / den);  // see [R22]
      end
    end
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ms_q   <= 32'h0;
      per_q  <= 16'h0;
      last_q <= `QPC_RST_WORD;
      rpm_q  <= `QPC_RST_WORD;
    end
    else if (ce)
    begin
      ms_q   <= ms_d;
      per_q  <= per_d;
      last_q <= last_d;
      rpm_q  <= rpm_d;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [31:0] rd_q, rd_d;
  always_comb
  begin
    rd_d = 32'h0;
    if (rd)
    begin
      case (addr)
        `QPC_A_CTRL:   rd_d = {21'h0, ctrl_q};
        `QPC_A_TERM:   rd_d = term_q;
        `QPC_A_PRESET: rd_d = pre_q;
        `QPC_A_CMPLO:  rd_d = lo_q;
        `QPC_A_CMPHI:  rd_d = hi_q;
        `QPC_A_PPR:    rd_d = {16'h0, ppr_q};
        `QPC_A_REFR:   rd_d = {16'h0, refr_q};
        `QPC_A_STAT:   rd_d = {16'h0, err, 3'h0, out_q, halt_q, borrow_q, carry_q, cmpf_q};
        `QPC_A_COUNT:  rd_d = cnt_q;
        `QPC_A_RPM:    rd_d = rpm_q;
        default:       rd_d = 32'h0;
      endcase
    end
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
      rd_q <= 32'h0;
    else if (ce)
      rd_q <= rd_d;
  end
  assign rdata              = rd_q;
  assign cmp_out            = out_q;
  assign cmp_irq            = irq_q;
  assign compare_flag_bit   = cmpf_q;
  assign overflow_flag_bit  = carry_q;
  assign underflow_flag_bit = borrow_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_up_step;
    ce && step_ok && up && !pre_rise && !run_rise && !ring_act && cnt_q != `QPC_CNT_MAX;
  endsequence
  property p_up_step;
    @(posedge mclk) disable iff (rst) s_up_step |=> cnt_q == $past(cnt_q) + 32'sh1;
  endproperty
  a_up_step: assert property (p_up_step) else $error("up step lost"); // see [R1]
  property p_stop_hold;
    @(posedge mclk) disable iff (rst) ce && !run && !pre_rise |=> cnt_q == $past(cnt_q);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("count moved while stopped"); // see [R2]
  property p_out_off;
    @(posedge mclk) disable iff (rst) ce && !run |=> !cmp_out;
  endproperty
  a_out_off: assert property (p_out_off) else $error("output on while stopped"); // see [R2]
  property p_ovf;
    @(posedge mclk) disable iff (rst)
      ce && step_ok && up && !ring_act && !pre_rise && !run_rise && cnt_q == `QPC_CNT_MAX
      |=> overflow_flag_bit && halt_q && cnt_q == `QPC_CNT_MAX;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged"); // see [R5]
  property p_preset;
    @(posedge mclk) disable iff (rst) ce && pre_rise && !run_rise
      |=> cnt_q == $past(pre_q) && !overflow_flag_bit && !underflow_flag_bit;
  endproperty
  a_preset: assert property (p_preset) else $error("preset not applied"); // see [R6]
  property p_ring_up;
    @(posedge mclk) disable iff (rst) ce && step_ok && up && ring_act && !pre_rise
      && !run_rise && cnt_q + 32'sh1 == term_q |=> cnt_q == 32'sh0 && overflow_flag_bit;
  endproperty
  a_ring_up: assert property (p_ring_up) else $error("ring wrap up wrong"); // see [R7]
  property p_ring_dn;
    @(posedge mclk) disable iff (rst) ce && step_ok && dn && ring_act && !pre_rise
      && !run_rise && cnt_q == 32'sh0 |=> cnt_q == $past(term_q) - 32'sh1 && underflow_flag_bit;
  endproperty
  a_ring_dn: assert property (p_ring_dn) else $error("ring wrap down wrong"); // see [R8]
  property p_cmpflag;
    @(posedge mclk) disable iff (rst) ce && cnt_q > term_q |=> compare_flag_bit;
  endproperty
  a_cmpflag: assert property (p_cmpflag) else $error("compare flag not set"); // see [R4]
  sequence s_eq_enter;
    ce && run && task_en && eq && !eq_q;
  endsequence
  property p_irq;
    @(posedge mclk) disable iff (rst) s_eq_enter |=> cmp_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("task interrupt missing"); // see [R21]
  // at most one count action per cycle outside active ring mode, preset and restart
  property p_edge_once;
    @(posedge mclk) disable iff (rst) ce && !pre_rise && !run_rise && !ring_act
      |=> cnt_q == $past(cnt_q) || cnt_q == $past(cnt_q) + 32'sh1
          || cnt_q == $past(cnt_q) - 32'sh1;
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("double edge"); // see [R23]
endmodule : qpc_counter

// ### qpc_encoder.sv
// encoder and preset source model driving the counter pins
`timescale 1ns/1ps
module qpc_encoder #(
  parameter int HOLD = 4
) (
  input  wire logic mclk,
  output logic      phase_a,
  output logic      phase_b,
  output logic      preset_pin
);
  initial
  begin
    phase_a = 1'b0;
    phase_b = 1'b0;
    preset_pin = 1'b0;
  end
  // each level stands HOLD cycles so one edge gives one action
  task automatic put(input logic a, input logic b, input logic p);
    @(posedge mclk);
    phase_a <= a;
    phase_b <= b;
    preset_pin <= p;
    repeat (HOLD - 1) @(posedge mclk);
  endtask : put
  task automatic pulse_a();
    put(1'b1, phase_b, 1'b0);
    put(1'b0, phase_b, 1'b0);
  endtask : pulse_a
  task automatic pulse_b();
    put(phase_a, 1'b1, 1'b0);
    put(phase_a, 1'b0, 1'b0);
  endtask : pulse_b
  // phase b doubles as the direction level
  task automatic set_b(input logic v);
    put(phase_a, v, 1'b0);
  endtask : set_b
  task automatic ext_preset();
    put(phase_a, phase_b, 1'b1);
    put(phase_a, phase_b, 1'b0);
  endtask : ext_preset
  // one quadrature edge, forward order ab 00 10 11 01
  task automatic step(input logic fwd);
    logic [1:0] s;
    s = {phase_a, phase_b};
    s = fwd ? {~s[0], s[1]} : {s[0], ~s[1]};
    put(s[1], s[0], 1'b0);
  endtask : step
endmodule : qpc_encoder

// ### tb.sv
// self-checking bench for the pulse counter
`timescale 1ns/1ps
`include "qpc_defines.svh"
module tb;
  import qpc_pkg::*;
  localparam logic [31:0] RUN  = 32'h1;
  localparam logic [31:0] RING = 32'h2;
  localparam logic [31:0] M_PD = 32'h4;
  localparam logic [31:0] M_CW = 32'h8;
  localparam logic [31:0] M_X4 = 32'hc;
  localparam logic [31:0] EXT  = 32'h10;
  localparam logic [31:0] IPR  = 32'h20;
  localparam logic [31:0] LAT  = 32'h40;
  localparam logic [31:0] PNT  = 32'h80;
  localparam logic [31:0] ZON  = 32'h100;
  localparam logic [31:0] TSK  = 32'h200;
  localparam logic [31:0] PAIR = 32'h400;
  logic        mclk;
  logic        rst;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic        ce;
  logic [31:0] rdata;
  logic        cmp_out;
  logic        cmp_irq;
  logic        compare_flag_bit;
  logic        overflow_flag_bit;
  logic        underflow_flag_bit;
  logic        phase_a;
  logic        phase_b;
  logic        preset_pin;
  logic [31:0] rv;
  logic [31:0] pv;
  int          err_count;
  int          samples_checked;
  int          irq_seen;
  int          seed;
  int          n;
  int          m;

  // ----------------------------------------
  // design and pin source
  // ----------------------------------------
  qpc_counter #(.MS_CYCLES(10)) i_dut (
    .mclk               (mclk),
    .rst                (rst),
    .ce                 (ce),
    .phase_a            (phase_a),
    .phase_b            (phase_b),
    .preset_pin         (preset_pin),
    .addr               (addr),
    .wdata              (wdata),
    .wr                 (wr),
    .rd                 (rd),
    .rdata              (rdata),
    .cmp_out            (cmp_out),
    .cmp_irq            (cmp_irq),
    .compare_flag_bit   (compare_flag_bit),
    .overflow_flag_bit  (overflow_flag_bit),
    .underflow_flag_bit (underflow_flag_bit)
  );
  qpc_encoder i_enc (
    .mclk       (mclk),
    .phase_a    (phase_a),
    .phase_b    (phase_b),
    .preset_pin (preset_pin)
  );

  // ----------------------------------------
  // clock, interrupt tally, watchdog
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
  end
  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    if (rst)
      irq_seen <= 0;
    else if (cmp_irq === 1'b1)
      irq_seen <= irq_seen + 1;
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_count++;
    finish_test();
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rpm_exp(input int d, input int ppr, input int refr);
    return 32'(d * 60000 / (ppr * refr));
  endfunction : rpm_exp
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  task automatic cnt(input logic [31:0] e);
    logic [31:0] v;
    rd_reg(`QPC_A_COUNT, v);
    chk("count", v, e);
  endtask : cnt
  task automatic err_code(input logic [31:0] e);
    logic [31:0] v;
    rd_reg(`QPC_A_STAT, v);
    chk("error_code", 32'(v[15:8]), e);
  endtask : err_code
  task automatic do_pre(input logic [31:0] v, input logic [31:0] c);
    wr_reg(`QPC_A_PRESET, v);
    wr_reg(`QPC_A_CTRL, c | IPR);
    wr_reg(`QPC_A_CTRL, c);
    repeat (2) @(posedge mclk);
    #1;
  endtask : do_pre
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    seed = 32'h22d741f5;
    err_count = 0;
    samples_checked = 0;
    rst = 1'b1;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    ce = 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(`QPC_A_PPR, rv);
    chk("ppr", rv, 32'h1);
    rd_reg(`QPC_A_STAT, rv);
    chk("stat", rv, 32'h0);
    n = 3 + ($unsigned($random(seed)) % 5);
    wr_reg(`QPC_A_TERM, 32'h4);
    wr_reg(`QPC_A_CMPLO, 32'(n));
    wr_reg(`QPC_A_CTRL, RUN | PNT | TSK);
    repeat (n) i_enc.pulse_a();
    cnt(32'(n));
    chk("cmp_out", 32'(cmp_out), 32'h1);
    chk("irq", 32'(irq_seen), 32'h1);
    chk("cmp_flag", 32'(compare_flag_bit), 32'(n > 4));
    wr_reg(`QPC_A_CTRL, PNT | TSK);
    i_enc.pulse_a();
    cnt(32'(n));
    chk("cmp_stop", 32'(cmp_out), 32'h0);
    wr_reg(`QPC_A_CTRL, RUN | LAT);
    cnt(32'(n));
    wr_reg(`QPC_A_CTRL, 32'h0);
    wr_reg(`QPC_A_CTRL, RUN | M_PD);
    cnt(32'h0);
    i_enc.set_b(1'b1);
    repeat (3) i_enc.pulse_a();
    i_enc.set_b(1'b0);
    i_enc.pulse_a();
    cnt(32'hfffffffe);
    wr_reg(`QPC_A_CTRL, RUN | M_CW);
    repeat (2) i_enc.pulse_a();
    i_enc.pulse_b();
    cnt(32'hffffffff);
    wr_reg(`QPC_A_CTRL, RUN | M_X4);
    n = 4 * (1 + ($unsigned($random(seed)) % 4));
    m = 4 * ($unsigned($random(seed)) % 3);
    repeat (n) i_enc.step(1'b1);
    cnt(32'(n - 1));
    repeat (m) i_enc.step(1'b0);
    cnt(32'(n - m - 1));
    // a pulse that comes and goes while the clock enable is low is never seen
    @(posedge mclk);
    ce <= 1'b0;
    i_enc.pulse_a();
    ce <= 1'b1;
    cnt(32'(n - m - 1));
    pv = $random(seed);
    do_pre(pv, RUN);
    cnt(pv);
    pv = $random(seed);
    wr_reg(`QPC_A_PRESET, pv);
    wr_reg(`QPC_A_CTRL, RUN | EXT);
    i_enc.ext_preset();
    cnt(pv);
    do_pre(32'h7fffffff, RUN);
    repeat (2) i_enc.pulse_a();
    cnt(32'h7fffffff);
    chk("carry", 32'(overflow_flag_bit), 32'h1);
    do_pre(32'h0, RUN);
    chk("carry_clr", 32'(overflow_flag_bit), 32'h0);
    i_enc.pulse_a();
    cnt(32'h1);
    i_enc.set_b(1'b1);
    do_pre(32'h80000000, RUN | M_PD);
    i_enc.pulse_a();
    cnt(32'h80000000);
    chk("borrow", 32'(underflow_flag_bit), 32'h1);
    wr_reg(`QPC_A_CTRL, 32'h0);
    repeat (2) @(posedge mclk);
    #1;
    chk("borrow_off", 32'(underflow_flag_bit), 32'h0);
    i_enc.set_b(1'b0);
    wr_reg(`QPC_A_TERM, 32'h5);
    wr_reg(`QPC_A_CTRL, RUN | RING);
    repeat (5) i_enc.pulse_a();
    cnt(32'h0);
    chk("ring_carry", 32'(overflow_flag_bit), 32'h1);
    wr_reg(`QPC_A_CTRL, RUN | RING | M_PD);
    i_enc.set_b(1'b1);
    i_enc.pulse_a();
    cnt(32'h4);
    chk("ring_borrow", 32'(underflow_flag_bit), 32'h1);
    i_enc.set_b(1'b0);
    wr_reg(`QPC_A_CTRL, 32'h0);
    wr_reg(`QPC_A_TERM, 32'h1);
    wr_reg(`QPC_A_CTRL, RUN | RING);
    repeat (3) i_enc.pulse_a();
    err_code(32'h11);
    cnt(32'h3);
    wr_reg(`QPC_A_CTRL, 32'h0);
    wr_reg(`QPC_A_CTRL, RUN | M_CW | PAIR);
    i_enc.pulse_a();
    err_code(32'h10);
    cnt(32'h0);
    wr_reg(`QPC_A_CMPLO, 32'ha);
    wr_reg(`QPC_A_CMPHI, 32'h3);
    wr_reg(`QPC_A_CTRL, 32'h0);
    wr_reg(`QPC_A_CTRL, RUN | ZON);
    err_code(32'h12);
    wr_reg(`QPC_A_CMPLO, 32'h1);
    wr_reg(`QPC_A_CMPHI, 32'h2);
    wr_reg(`QPC_A_CTRL, 32'h0);
    wr_reg(`QPC_A_CTRL, RUN | ZON);
    i_enc.pulse_a();
    #1;
    chk("zone_in", 32'(cmp_out), 32'h1);
    repeat (2) i_enc.pulse_a();
    #1;
    chk("zone_out", 32'(cmp_out), 32'h0);
    wr_reg(`QPC_A_REFR, 32'd80);
    wr_reg(`QPC_A_CTRL, 32'h0);
    wr_reg(`QPC_A_CTRL, RUN);
    fork
      repeat (300) i_enc.pulse_a();
      begin
        repeat (2000) @(posedge mclk);
        rd_reg(`QPC_A_RPM, rv);
      end
    join
    chk("rpm", rv, rpm_exp(100, 1, 80));
    finish_test();
  end
endmodule : tb
